// file: adc_spi_pkg.sv
// Shared constants, types and check-code helpers for the serial command interface.
package adc_spi_pkg;

    // ==================================================================
    // Register addresses
    // ==================================================================
    localparam logic [3:0] ADDR_REV       = 4'h0;
    localparam logic [3:0] ADDR_STATUS    = 4'h2;
    localparam logic [3:0] ADDR_CTRL      = 4'h3;
    localparam logic [3:0] ADDR_CFG2      = 4'h5;
    localparam logic [3:0] ADDR_CFG4      = 4'h7;
    localparam logic [3:0] ADDR_MAP_LAST  = 4'hE;
    localparam logic [3:0] ADDR_CHK       = 4'hF;
    localparam logic [3:0] ADDR_LAST      = 4'hF;
    localparam int         REG_COUNT      = 16;

    // ==================================================================
    // Field positions and reset values
    // ==================================================================
    localparam int STAT_NEW_BIT      = 0;
    localparam int STAT_LINK_ERR_BIT = 4;
    localparam int STAT_MAP_ERR_BIT  = 5;
    localparam int CFG2_PIN_SEL_BIT  = 0;
    localparam int CFG4_LINK_CRC_BIT = 0;
    localparam int CFG4_HDR_BIT      = 1;
    localparam int CFG4_RES16_BIT    = 2;
    localparam int CFG4_MAP_CRC_BIT  = 3;

    localparam logic [7:0] REG_RESET = 8'h00;
    // Revision code value is arbitrary.
    localparam logic [7:0] REV_CODE  = 8'h5A;

    // ==================================================================
    // Command encoding and frame sizes
    // ==================================================================
    localparam logic [3:0] OP_READ        = 4'h4;
    localparam logic [3:0] OP_WRITE       = 4'h8;
    localparam logic [5:0] MIN_BITS       = 6'h10;
    localparam logic [5:0] MIN_BITS_CHK   = 6'h18;
    localparam logic [5:0] MSB_END_PLAIN  = 6'h08;
    localparam logic [5:0] MSB_END_HDR    = 6'h10;
    localparam logic [5:0] FALL_CNT_MAX   = 6'h3F;

    // ==================================================================
    // Check code: remainder by 100000111 with the leading byte inverted
    // ==================================================================
    localparam logic [7:0] CRC_INIT = 8'hFF;
    localparam logic [7:0] CRC_POLY = 8'h07;

    typedef struct packed {
        logic [3:0] op;
        logic [3:0] addr;
        logic [7:0] data;
    } cmd_t;

    typedef enum logic [1:0] {
        PH_IDLE  = 2'b00,
        PH_PRE   = 2'b01,
        PH_SHIFT = 2'b11,
        PH_TAIL  = 2'b10
    } phase_t;

    // One byte through the divider, most significant bit first.
    function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] b);
        logic [7:0] c;
        c = crc ^ b;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
        end
        return c;
    endfunction : crc8_step

    // The first n bytes of a left-aligned word.
    function automatic logic [7:0] crc8_bytes(input logic [31:0] d, input logic [2:0] n);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 0; i < 4; i++) begin
            if (i < int'(n)) begin
                c = crc8_step(c, d[31-8*i -: 8]);
            end
        end
        return c;
    endfunction : crc8_bytes

endpackage : adc_spi_pkg

// file: conv_buffer.sv
// Two-entry result buffer with valid and ready on both sides.
`timescale 1ns/1ps
module conv_buffer #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 2
) (
    // System.
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Filling side.
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    // Draining side.
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

    logic [WIDTH-1:0] mem_r [0:DEPTH-1];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      cnt_r;
    logic [AW:0]      cnt_nxt;
    logic             nfull_r;
    wire              push = in_valid & nfull_r;
    wire              pop  = out_valid & out_ready;

    // Occupancy; ready is registered so the filling side sees a clean level.
    assign cnt_nxt   = cnt_r + (AW + 1)'(push) - (AW + 1)'(pop);
    assign in_ready  = nfull_r;
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rd_ptr_r];

    // Storage and pointers.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r    <= '0;
            nfull_r  <= 1'b1;
        end else begin
            if (push) begin
                mem_r[wr_ptr_r] <= in_data;
                wr_ptr_r        <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + AW'(1);
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + AW'(1);
            end
            cnt_r   <= cnt_nxt;
            nfull_r <= (cnt_nxt != FULL_CNT);
        end
    end

endmodule : conv_buffer

// file: adc_spi_command_interface.sv
// Serial command, register and conversion read-out logic of the converter.
`timescale 1ns/1ps

// Overview of operation
// - Map code covers 00h-0Eh minus 02h, 03h.
// - Enabled check compares stored code, flags mismatch.
// - Mismatch flag clears by writing one only.
// - Map check gated by fourth configuration enable bit.
// - Codes use polynomial 107h, leading byte inverted.
// - Decode last 16 or 24 bits at frame end.
// - Clock idles low, drive rising, sample falling.
// - New read accepted while previous data shifts out.
// - Check mode: last byte check, two before command.
// - No-operation is two zero bytes plus D7h.
// - Read command is 40h plus address.
// - Write command is 80h plus address, data.
// - Read data returns in the following frame.
// - Unmapped reads give 00h, data MSB first.
// - Writes to unmapped addresses are discarded.
// - Register byte followed by zero pad bytes.
// - Leading pad bytes excluded from input check.
// - Output check covers all preceding output bytes.
// - Input check fail: flag, skip, block writes.
// - Buffered result shifts out without command, repeatable.
// - Pending read replaces conversion data this frame.
// - Ready returns high at MSB byte eighth fall, unless one-shot without a start.
// - Stopped read: ready high, new bit cleared; the code leaves both ready and the new bit at their levels.
// - Before first clock: hold or follow ready.
module adc_spi_command_interface (
    // System.
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Serial link pins.
    input  wire logic        cs_n,
    input  wire logic        sclk,
    input  wire logic        sdi,
    output logic             serial_out_ready_pin,
    output logic             serial_out_ready_pin_oe,
    output logic             conversion_ready_n,
    // Conversion results and control mode.
    input  wire logic [23:0] conv_data,
    input  wire logic        conv_valid,
    output logic             conv_ready,
    input  wire logic        conv_start,
    input  wire logic        one_shot_mode,
    // Settings toward the conversion control logic.
    output logic [7:0]       conversion_control
);

    // ==================================================================
    // Pin synchronisers and edge detection
    // ==================================================================
    logic cs_m_r, cs_s_r, cs_d_r;
    logic sclk_m_r, sclk_s_r, sclk_d_r;
    logic sdi_m_r, sdi_s_r;

    // Two flops per pin; a third copy of chip select and clock finds edges.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            {cs_m_r, cs_s_r, cs_d_r}       <= 3'h7;
            {sclk_m_r, sclk_s_r, sclk_d_r} <= 3'h0;
            {sdi_m_r, sdi_s_r}             <= 2'h0;
        end else begin
            {cs_m_r, cs_s_r, cs_d_r}       <= {cs_n, cs_m_r, cs_s_r};
            {sclk_m_r, sclk_s_r, sclk_d_r} <= {sclk, sclk_m_r, sclk_s_r};
            {sdi_m_r, sdi_s_r}             <= {sdi, sdi_m_r};
        end
    end

    // Clock edges count only inside a frame; clock idles low so rise comes first.
    wire cs_fall    = cs_d_r & ~cs_s_r;
    wire cs_rise    = ~cs_d_r & cs_s_r;
    wire sclk_rise  = ~cs_s_r & ~sclk_d_r & sclk_s_r;
    wire sclk_fall  = ~cs_s_r & sclk_d_r & ~sclk_s_r;

    // ==================================================================
    // Register file and status flags
    // ==================================================================
    logic [7:0] regs_r [0:adc_spi_pkg::REG_COUNT-1];
    logic       data_new_r;
    logic       link_err_r;
    logic       map_err_r;
    logic [7:0] status_byte;
    logic [7:0] map_crc;

    wire [7:0] cfg2 = regs_r[adc_spi_pkg::ADDR_CFG2];
    wire [7:0] cfg4 = regs_r[adc_spi_pkg::ADDR_CFG4];
    wire       pin_sel  = cfg2[adc_spi_pkg::CFG2_PIN_SEL_BIT];
    wire       crc_en   = cfg4[adc_spi_pkg::CFG4_LINK_CRC_BIT];
    wire       hdr_en   = cfg4[adc_spi_pkg::CFG4_HDR_BIT];
    wire       res16    = cfg4[adc_spi_pkg::CFG4_RES16_BIT];
    wire       map_chk  = cfg4[adc_spi_pkg::CFG4_MAP_CRC_BIT];

    // Status byte doubles as the optional frame header.
    always_comb begin
        status_byte = 8'h00;
        status_byte[adc_spi_pkg::STAT_NEW_BIT]      = data_new_r;
        status_byte[adc_spi_pkg::STAT_LINK_ERR_BIT] = link_err_r;
        status_byte[adc_spi_pkg::STAT_MAP_ERR_BIT]  = map_err_r;
    end

    // Running map code; the status and control bytes change by themselves
    // and would raise false alarms, so they are left out.
    always_comb begin
        map_crc = adc_spi_pkg::CRC_INIT;
        for (int i = 0; i <= int'(adc_spi_pkg::ADDR_MAP_LAST); i++) begin
            if (i != int'(adc_spi_pkg::ADDR_STATUS) && i != int'(adc_spi_pkg::ADDR_CTRL)) begin
                map_crc = adc_spi_pkg::crc8_step(map_crc, regs_r[i]);
            end
        end
    end

    // The enable bit sits in a checked register, so it is covered too.
    wire map_err_set = map_chk & (map_crc != regs_r[adc_spi_pkg::ADDR_CHK]);

    // ==================================================================
    // Command decode at the end of a frame
    // ==================================================================
    logic [23:0] rx_r;
    logic [5:0]  fall_cnt_r;
    adc_spi_pkg::cmd_t cmd;
    logic [7:0]  chk_in;
    logic [7:0]  chk_calc;

    // Only the tail of the frame counts; leading pad bytes never reach
    // the check because they fall out of the window.
    assign cmd      = crc_en ? rx_r[23:8] : rx_r[15:0];
    assign chk_in   = rx_r[7:0];
    assign chk_calc = adc_spi_pkg::crc8_step(
                          adc_spi_pkg::crc8_step(adc_spi_pkg::CRC_INIT, cmd[15:8]),
                          cmd[7:0]);

    wire enough    = fall_cnt_r >= (crc_en ? adc_spi_pkg::MIN_BITS_CHK
                                           : adc_spi_pkg::MIN_BITS);
    wire chk_bad   = crc_en & (chk_calc != chk_in);
    wire end_ok    = cs_rise & enough;
    // All-zero commands, checked as D7h, fall through with no action.
    wire link_set  = end_ok & chk_bad;
    wire cmd_ok    = end_ok & ~chk_bad;
    wire do_read   = cmd_ok & (cmd.op == adc_spi_pkg::OP_READ);
    wire wr_cmd    = cmd_ok & (cmd.op == adc_spi_pkg::OP_WRITE);
    wire wr_map    = cmd.addr <= adc_spi_pkg::ADDR_LAST;
    wire wr_status = cmd.addr == adc_spi_pkg::ADDR_STATUS;
    wire wr_allow  = wr_cmd & wr_map & (~link_err_r | wr_status);
    wire st_wr     = wr_allow & wr_status;
    wire reg_wr    = wr_allow & ~wr_status & (cmd.addr != adc_spi_pkg::ADDR_REV);
    wire link_clr  = st_wr & cmd.data[adc_spi_pkg::STAT_LINK_ERR_BIT];
    wire map_clr   = st_wr & cmd.data[adc_spi_pkg::STAT_MAP_ERR_BIT];

    // Plain registers; revision code is fixed, status is held apart.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < adc_spi_pkg::REG_COUNT; i++) begin
                regs_r[i] <= adc_spi_pkg::REG_RESET;
            end
            regs_r[adc_spi_pkg::ADDR_REV] <= adc_spi_pkg::REV_CODE;
        end else if (reg_wr) begin
            regs_r[cmd.addr] <= cmd.data;
        end
    end

    // Error flags: a new event wins over a clear in the same cycle.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            link_err_r <= 1'b0;
            map_err_r  <= 1'b0;
        end else begin
            link_err_r <= link_set | (link_err_r & ~link_clr);
            map_err_r  <= map_err_set | (map_err_r & ~map_clr);
        end
    end

    // A read issued now is answered in the next frame only.
    logic       read_pend_r;
    logic [3:0] read_addr_r;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            read_pend_r <= 1'b0;
            read_addr_r <= 4'h0;
        end else if (cs_rise) begin
            read_pend_r <= do_read;
            read_addr_r <= do_read ? cmd.addr : read_addr_r;
        end
    end

    // ==================================================================
    // Conversion result buffer
    // ==================================================================
    logic [23:0] buf_data;
    logic        buf_valid;
    logic [23:0] conv_word_r;
    adc_spi_pkg::phase_t phase_r;
    wire frame_idle = (phase_r == adc_spi_pkg::PH_IDLE) & cs_s_r & ~cs_fall;
    // Results are taken only between frames so a word never changes mid-shift;
    // the buffer absorbs the stall.
    wire pop = buf_valid & frame_idle;

    conv_buffer #(
        .WIDTH (24),
        .DEPTH (2)
    ) u_buf (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_data   (conv_data),
        .in_valid  (conv_valid),
        .in_ready  (conv_ready),
        .out_data  (buf_data),
        .out_valid (buf_valid),
        .out_ready (pop)
    );

    // The same result stays readable until a newer one arrives.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            conv_word_r <= 24'h000000;
        end else if (pop) begin
            conv_word_r <= buf_data;
        end
    end

    // ==================================================================
    // Output frame assembly
    // ==================================================================
    logic [7:0]  rd_byte;
    logic [23:0] payload;
    logic [31:0] pre;
    logic [2:0]  nbytes;
    logic [7:0]  crc_out;
    logic [39:0] tx_word;
    logic [5:0]  tx_len;

    assign rd_byte = (read_addr_r == adc_spi_pkg::ADDR_STATUS) ? status_byte :
                     (read_addr_r <= adc_spi_pkg::ADDR_LAST)   ? regs_r[read_addr_r] :
                     8'h00;
    // Register byte first, then zero pads up to the data field's width.
    assign payload = read_pend_r ? {rd_byte, 16'h0000} :
                     res16       ? {conv_word_r[23:8], 8'h00} :
                     conv_word_r;
    assign pre     = hdr_en ? {status_byte, payload} : {payload, 8'h00};
    assign nbytes  = (res16 ? 3'h2 : 3'h3) + (hdr_en ? 3'h1 : 3'h0);
    assign crc_out = adc_spi_pkg::crc8_bytes(pre, nbytes);

    // Check byte lands right after the data, as in a conversion frame.
    always_comb begin
        tx_word = {pre, 8'h00};
        tx_len  = {nbytes, 3'b000};
        if (crc_en) begin
            tx_len = {nbytes + 3'h1, 3'b000};
            case (nbytes)
                3'h2:    tx_word[23:16] = crc_out;
                3'h3:    tx_word[15:8]  = crc_out;
                default: tx_word[7:0]   = crc_out;
            endcase
        end
    end

    // ==================================================================
    // Frame sequencing and shifting
    // ==================================================================
    logic [39:0] tx_r;
    logic [5:0]  len_r;
    logic        frame_conv_r;
    wire [5:0]   fall_inc = (fall_cnt_r == adc_spi_pkg::FALL_CNT_MAX) ? fall_cnt_r
                                                                       : fall_cnt_r + 6'h01;
    wire [5:0]   msb_end  = hdr_en ? adc_spi_pkg::MSB_END_HDR : adc_spi_pkg::MSB_END_PLAIN;
    wire         msb_done = sclk_fall & frame_conv_r & (fall_inc == msb_end);

    // Frame phase: before first clock, shifting, and after the data.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            phase_r <= adc_spi_pkg::PH_IDLE;
        end else if (cs_s_r) begin
            phase_r <= adc_spi_pkg::PH_IDLE;
        end else begin
            case (phase_r)
                adc_spi_pkg::PH_IDLE:  phase_r <= adc_spi_pkg::PH_PRE;
                adc_spi_pkg::PH_PRE:   if (sclk_rise) phase_r <= adc_spi_pkg::PH_SHIFT;
                adc_spi_pkg::PH_SHIFT: if (sclk_fall && fall_inc == len_r) begin
                    phase_r <= adc_spi_pkg::PH_TAIL;
                end
                default:               phase_r <= phase_r;
            endcase
        end
    end

    // Output word is frozen at frame start; input shifts on falling edges.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_r         <= 40'h0000000000;
            len_r        <= 6'h00;
            frame_conv_r <= 1'b0;
            rx_r         <= 24'h000000;
            fall_cnt_r   <= 6'h00;
        end else if (cs_fall) begin
            tx_r         <= tx_word;
            len_r        <= tx_len;
            frame_conv_r <= ~read_pend_r;
            fall_cnt_r   <= 6'h00;
        end else begin
            if (sclk_rise) begin
                tx_r <= {tx_r[38:0], 1'b0};
            end
            if (sclk_fall) begin
                rx_r       <= {rx_r[22:0], sdi_s_r};
                fall_cnt_r <= fall_inc;
            end
        end
    end

    // ==================================================================
    // Data-ready and pin drivers
    // ==================================================================
    // Reading the top data byte counts as a read attempt in any mode.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            conversion_ready_n <= 1'b1;
            data_new_r         <= 1'b0;
        end else if (pop) begin
            conversion_ready_n <= 1'b0;
            data_new_r         <= 1'b1;
        end else if (msb_done) begin
            // A start that meets the top byte's last fall must still raise ready.
            conversion_ready_n <= (one_shot_mode & ~conv_start) ? conversion_ready_n
                                                                 : 1'b1;
            data_new_r         <= 1'b0;
        end else if (conv_start) begin
            conversion_ready_n <= 1'b1;
        end
    end

    // Pin shows data while shifting; before that it holds or mirrors ready, after it shifts out zeros or mirrors ready.
    wire mirror = pin_sel & ((phase_r == adc_spi_pkg::PH_PRE) |
                             (phase_r == adc_spi_pkg::PH_TAIL));
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            serial_out_ready_pin    <= 1'b0;
            serial_out_ready_pin_oe <= 1'b0;
        end else begin
            serial_out_ready_pin_oe <= ~cs_s_r;
            if (sclk_rise && !(pin_sel && phase_r == adc_spi_pkg::PH_TAIL)) begin
                serial_out_ready_pin <= tx_r[39];
            end else if (mirror) begin
                serial_out_ready_pin <= conversion_ready_n;
            end
        end
    end

    assign conversion_control = regs_r[adc_spi_pkg::ADDR_CTRL];

endmodule : adc_spi_command_interface

// file: adc_spi_monitor.sv
// Port checker for the serial command interface.
`timescale 1ns/1ps
module adc_spi_monitor (
    // System.
    input wire logic       clk,
    input wire logic       rst_n,
    // Link and result side.
    input wire logic       cs_n,
    input wire logic       serial_out_ready_pin,
    input wire logic       serial_out_ready_pin_oe,
    input wire logic       conversion_ready_n,
    input wire logic       conv_valid,
    input wire logic       conv_ready,
    input wire logic       conv_start,
    input wire logic [7:0] conversion_control
);
    // ==============================================
    // Properties
    // ==============================================
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Chip select must clear the two-flop synchroniser before idle is assumed.
    sequence cs_idle;
        cs_n [*4];
    endsequence
    a_oe_idle_low: assert property (cs_idle |-> !serial_out_ready_pin_oe)
        else $error("pin driven while deselected");
    a_pin_idle_hold: assert property (cs_idle ##1 cs_n |-> $stable(serial_out_ready_pin))
        else $error("pin moved while deselected");
    a_oe_rise_cause: assert property ($rose(serial_out_ready_pin_oe) |-> !$past(cs_n, 3))
        else $error("pin enabled without select");
    a_oe_fall_cause: assert property ($fell(serial_out_ready_pin_oe) |-> $past(cs_n, 3))
        else $error("pin released while selected");
    a_start_ready_high: assert property (conv_start |-> ##[1:2] conversion_ready_n)
        else $error("ready not raised by start");
    a_ready_fall_idle: assert property ($fell(conversion_ready_n) |-> $past(cs_n, 3))
        else $error("result moved during a frame");
    a_fill_cause: assert property ($fell(conv_ready) |-> $past(conv_valid))
        else $error("buffer filled without a valid");
    a_ctrl_frame_end: assert property (!$stable(conversion_control) |-> $past(cs_n, 3))
        else $error("control changed inside a frame");
endmodule : adc_spi_monitor

bind adc_spi_command_interface adc_spi_monitor u_mon (.clk(clk), .rst_n(rst_n), .cs_n(cs_n),
    .serial_out_ready_pin(serial_out_ready_pin), .serial_out_ready_pin_oe(serial_out_ready_pin_oe),
    .conversion_ready_n(conversion_ready_n), .conv_valid(conv_valid), .conv_ready(conv_ready),
    .conv_start(conv_start), .conversion_control(conversion_control));

// file: spi_host_model.sv
// Host controller model driving mode-1 frames on the serial link.
`timescale 1ns/1ps
module spi_host_model (
    // Serial link toward the device.
    output logic      cs_n,
    output logic      sclk,
    output logic      sdi,
    input  wire logic pin
);
    // ==============================================
    // Frame engine
    // ==============================================
    // Clock stands low between frames; sdi is inverted on release so no stale bit lingers.
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi  = 1'b0;
    end
    // High phase is long so output launched on the rise has settled before the fall.
    task automatic frame(input int n, input logic [39:0] tx, output logic [39:0] rx);
        rx = '0;
        #7 cs_n = 1'b0;
        #200;
        for (int i = n - 1; i >= 0; i--) begin
            sclk = 1'b1;
            sdi  = tx[i];
            #125 sclk = 1'b0;
            rx[i] = pin;
            #75;
        end
        cs_n = 1'b1;
        sdi  = ~sdi;
        #400;
    endtask : frame
endmodule : spi_host_model

// file: tb_top.sv
// Self-checking bench for the serial command interface.
`timescale 1ns/1ps
module tb_top;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cs_n, sclk, sdi, pin;
    logic [23:0] conv_data = 24'h000000;
    logic        conv_valid = 1'b0;
    logic        conv_start = 1'b0;
    logic        one_shot_mode = 1'b0;
    logic        conv_ready, conversion_ready_n;
    logic [7:0]  conversion_control, d, p;
    logic [23:0] w1, w2, w3;
    logic [39:0] rx;
    int          n_fail = 0;
    int          checks_done = 0;
    // 40 MHz system clock.
    always #12.5 clk = ~clk;
    spi_host_model host (.cs_n(cs_n), .sclk(sclk), .sdi(sdi), .pin(pin));
    adc_spi_command_interface dut (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk),
        .sdi(sdi), .serial_out_ready_pin(pin), .serial_out_ready_pin_oe(),
        .conversion_ready_n(conversion_ready_n), .conv_data(conv_data),
        .conv_valid(conv_valid), .conv_ready(conv_ready), .conv_start(conv_start),
        .one_shot_mode(one_shot_mode), .conversion_control(conversion_control));
    // ==============================================
    // Helpers
    // ==============================================
    // Bitwise divider; an all-ones start inverts the leading byte.
    function automatic logic [7:0] crc_of(input logic [31:0] v, input int nb);
        logic [7:0] c;
        c = 8'hFF;
        for (int i = 8 * nb - 1; i >= 0; i--) begin
            c = (c[7] ^ v[i]) ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
        end
        return c;
    endfunction : crc_of
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic conclude();
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude
    // A hung frame ends the run as a failure.
    initial begin
        #500000;
        n_fail++;
        conclude();
    end
    // ==============================================
    // Scenarios
    // ==============================================
    initial begin
        void'($urandom(5));
        w1 = 24'($urandom);
        w2 = 24'($urandom);
        w3 = 24'($urandom);
        d  = 8'($urandom);
        p  = 8'($urandom);
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        // Two results arrive mid-frame, so nothing drains and the buffer fills.
        fork
            host.frame(24, 40'h0, rx);
            begin
                repeat (12) @(posedge clk);
                conv_valid <= 1'b1;
                conv_data  <= w1;
                @(posedge clk);
                conv_data  <= w2;
                @(posedge clk);
                conv_valid <= 1'b0;
                repeat (2) @(posedge clk);
                chk(32'(conv_ready), 32'h0);
            end
        join
        chk(32'(conv_ready), 32'h1);
        chk(32'(conversion_ready_n), 32'h0);
        host.frame(24, {16'h0, p, 8'h83, d}, rx);
        chk(rx[23:0], w2);
        chk(32'(conversion_ready_n), 32'h1);
        chk(32'(conversion_control), 32'(d));
        host.frame(16, {24'h0, 8'h43, p}, rx);
        chk(rx[15:0], w2[23:8]);
        host.frame(24, {24'h0, 8'h40, p}, rx);
        chk(rx[23:0], {d, 16'h0000});
        host.frame(24, {24'h0, 8'h87, 8'h01}, rx);
        chk(rx[23:0], {adc_spi_pkg::REV_CODE, 16'h0000});
        // Link check on: a corrupted write must be refused.
        host.frame(32, {16'h0, 8'h83, ~d, crc_of({8'h83, ~d}, 2) ^ 8'h01}, rx);
        chk(rx[31:0], {w2, crc_of(w2, 3)});
        chk(32'(conversion_control), 32'(d));
        host.frame(32, {16'h0, 8'h42, 8'h00, crc_of(24'h004200, 2)}, rx);
        chk(32'(crc_of(24'h0, 2)), 32'hD7);
        host.frame(32, {16'h0, 24'h0000D7}, rx);
        chk(32'(rx[31:24]), 32'h10);
        chk(32'(rx[23:8]), 32'h0);
        chk(32'(rx[7:0]), 32'(crc_of(24'h100000, 3)));
        // Writes stay blocked until the link flag is cleared; then the map check runs.
        host.frame(32, {16'h0, 8'h83, ~d, crc_of({8'h83, ~d}, 2)}, rx);
        chk(32'(conversion_control), 32'(d));
        host.frame(32, {16'h0, 8'h82, 8'h10, crc_of(24'h008210, 2)}, rx);
        host.frame(32, {16'h0, 8'h87, 8'h0B, crc_of(24'h00870B, 2)}, rx);
        host.frame(32, {16'h0, 8'h42, 8'h00, crc_of(24'h004200, 2)}, rx);
        host.frame(40, {16'h0, 24'h0000D7}, rx);
        chk(rx[39:8], 32'h20200000);
        // One-shot: reading leaves ready low until a new conversion starts.
        conv_data     <= w3;
        conv_valid    <= 1'b1;
        one_shot_mode <= 1'b1;
        @(posedge clk);
        conv_valid    <= 1'b0;
        repeat (8) @(posedge clk);
        host.frame(40, {16'h0, 24'h0000D7}, rx);
        chk(rx[39:8], {8'h21, w3});
        chk(32'(rx[7:0]), 32'(crc_of({8'h21, w3}, 4)));
        chk(32'(conversion_ready_n), 32'h0);
        conv_start <= 1'b1;
        @(posedge clk);
        conv_start <= 1'b0;
        repeat (3) @(posedge clk);
        chk(32'(conversion_ready_n), 32'h1);
        conclude();
    end
endmodule : tb_top
